// *** rtl/csru_map.svh ***
// Purpose: Constants for the stack, reset and address unit
// Assumes: Included by the core only
// Notes: Offsets are byte addresses on the plain register port
`ifndef CSRU_MAP_SVH
`define CSRU_MAP_SVH
// Pointer and program counter reset values, RAM depth, advised data pointer maximum
`define CSRU_PTR_RST 8'h00
`define CSRU_PC_RST 14'h0000
`define CSRU_RAM_DEPTH 256
`define CSRU_DSP_ADVISED_MAX 8'hd8
// Clocking
`define CSRU_REF_CLK_MHZ 6
`define CSRU_CORE_PERIOD_NS 8
// Register offsets
`define CSRU_OFF_STATUS 8'h00
`define CSRU_OFF_USBADDR 8'h01
`define CSRU_OFF_INTCTL 8'h02
// Status and control fields
`define CSRU_STAT_RUN_BIT 0
`define CSRU_STAT_POR_BIT 4
`define CSRU_STAT_WDT_BIT 6
`define CSRU_STAT_POR_VAL 8'h11
`define CSRU_USBADDR_RST 7'h00
`endif

// *** rtl/csru_pkg.sv ***
// Purpose: Types shared by the stack, reset and address unit
// Assumes: Nothing beyond the constant header
// Notes: Command and mode encodings are left to the tool
package csru_pkg;
  typedef enum logic [3:0] {
    CSRU_CMD_NONE,
    CSRU_CMD_INT_ACK,
    CSRU_CMD_CALL,
    CSRU_CMD_INT_RETURN,
    CSRU_CMD_SUB_RETURN,
    CSRU_CMD_PUSH,
    CSRU_CMD_POP,
    CSRU_CMD_LOAD_PSTK,
    CSRU_CMD_SWAP_DSP,
    CSRU_CMD_RD,
    CSRU_CMD_WR,
    CSRU_CMD_EI,
    CSRU_CMD_DI
  } csru_cmd_t;
  typedef enum logic [1:0] {
    CSRU_MODE_IMM,
    CSRU_MODE_DIR,
    CSRU_MODE_IDX
  } csru_mode_t;
  typedef enum logic [1:0] {
    CSRU_ST_IDLE,
    CSRU_ST_SAVE2,
    CSRU_ST_REST2
  } csru_state_t;
endpackage

// *** rtl/csru_core.sv ***
// Purpose: Stack pointers, operand addressing and reset entry of the core
// Assumes: core_clk is the PLL output, locked when pll_lock is high
// Notes: Sequencer issues one command when busy is low
`timescale 1ns/100ps
`include "csru_map.svh"

////////////////////////////////////////////////////////////////////////
// Contract
// - Reset clears program stack pointer; program stack grows upward.
// - Program stack pointer loads from accumulator; never readable.
// - Interrupt acknowledge disables interrupts, saves PC and flags.
// - Write first byte, increment, write second byte, increment.
// - Return from interrupt: decrement, read second, decrement, read first.
// - Interrupts re-enabled only after PC and flags restored.
// - Call saves PC and flags like interrupt, pointer plus two.
// - Subroutine return restores PC only, flags kept, pointer minus two.
// - 256-byte data RAM with 8-bit address, shared by everything.
// - Push pre-decrements data stack pointer, then writes.
// - Pop reads at data stack pointer, then post-increments.
// - Data stack pointer resets to zero; push then writes 0xFF.
// - Swap exchanges accumulator and data stack pointer in one step.
// - Immediate mode uses the second instruction byte as constant.
// - Direct mode reads or writes the RAM byte at given address.
// - Indexed address is instruction constant plus index register.
// - Internal clock comes from PLL on 6 MHz crystal reference.
// - Exactly two reset sources: power-on and watchdog.
// - Any reset restores defaults, clears USB address, interrupts, pointers.
// - Status bit 4 records power-on, bit 6 records watchdog.
// - Execution starts at 0x0000; reset pushes nothing on stack.
module csru_core #(
  parameter int RAM_DEPTH = `CSRU_RAM_DEPTH
) (
  // Clock and reset sources
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic watchdog_reset_source,
  input wire logic pll_lock,
  // Sequencer command
  input wire logic cmd_valid,
  input wire csru_pkg::csru_cmd_t cmd,
  input wire csru_pkg::csru_mode_t mode,
  input wire logic [7:0] operand,
  input wire logic [7:0] index_register,
  input wire logic [7:0] accumulator,
  input wire logic [13:0] pc_in,
  input wire logic carry_in,
  input wire logic zero_in,
  // Sequencer answer
  output logic busy,
  output logic done,
  output logic [7:0] data_out,
  output logic pc_load,
  output logic flags_load,
  output logic [13:0] pc_out,
  output logic carry_out,
  output logic zero_out,
  output logic int_enable,
  output logic cpu_run,
  output logic [6:0] usb_dev_addr,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  import csru_pkg::*;

  ////////////////////////////////////////////////////////////////////
  // Operand address: constant alone or constant plus index
  function automatic logic [7:0] opnd_addr_f(
    input csru_mode_t m,
    input logic [7:0] k,
    input logic [7:0] x
  );
    opnd_addr_f = (m == CSRU_MODE_IDX) ? k + x : k;
  endfunction

  ////////////////////////////////////////////////////////////////////
  // State
  // shared data RAM
  logic [7:0] mem [0:RAM_DEPTH-1];
  csru_state_t st_r, st_nxt;
  logic [7:0] pstk_r, pstk_nxt;
  logic [7:0] dsp_r, dsp_nxt;
  logic [7:0] hold_r, hold_nxt;
  logic from_int_r, from_int_nxt;
  logic ie_r, ie_nxt;
  logic [7:0] dout_r, dout_nxt;
  logic done_r, done_nxt;
  logic pcld_r, pcld_nxt;
  logic flld_r, flld_nxt;
  logic [13:0] pc_r, pc_nxt;
  logic cy_r, cy_nxt;
  logic zf_r, zf_nxt;
  logic boot_r;
  logic [7:0] stat_r;
  logic [6:0] uadr_r;
  logic [7:0] rdat_r;
  logic ram_we;
  logic [7:0] ram_wa;
  logic [7:0] ram_wd;

  ////////////////////////////////////////////////////////////////////
  // Decoding
  // power-on or watchdog
  wire sys_rst = !rst_b || watchdog_reset_source;
  wire run_ok = stat_r[`CSRU_STAT_RUN_BIT] && pll_lock && !sys_rst;
  wire idle = (st_r == CSRU_ST_IDLE);
  wire accept = cmd_valid && idle && run_ok;
  wire [7:0] opnd_addr = opnd_addr_f(mode, operand, index_register);
  wire [7:0] pstk_dec = pstk_r - 8'h01;
  wire [7:0] pstk_inc = pstk_r + 8'h01;
  wire [7:0] dsp_dec = dsp_r - 8'h01;
  wire [7:0] dsp_inc = dsp_r + 8'h01;
  // First stacked byte carries flags and the PC high bits
  wire [7:0] save_hi = {carry_in, zero_in, pc_in[13:8]};
  wire rd_pop = idle && cmd == CSRU_CMD_POP;
  wire rd_opnd = idle && cmd == CSRU_CMD_RD;
  wire [7:0] ram_ra = rd_pop ? dsp_r : (rd_opnd ? opnd_addr : pstk_dec);
  wire [7:0] ram_rd = mem[ram_ra];
  wire wr_stat = reg_wr && reg_addr == `CSRU_OFF_STATUS;
  wire wr_uadr = reg_wr && reg_addr == `CSRU_OFF_USBADDR;
  wire wr_ictl = reg_wr && reg_addr == `CSRU_OFF_INTCTL;
  wire [7:0] rd_val =
    (reg_addr == `CSRU_OFF_STATUS) ? stat_r :
    (reg_addr == `CSRU_OFF_USBADDR) ? {1'b0, uadr_r} :
    (reg_addr == `CSRU_OFF_INTCTL) ? {7'h00, ie_r} : 8'h00;

  ////////////////////////////////////////////////////////////////////
  // Command sequencing
  always_comb begin
    st_nxt = st_r;
    pstk_nxt = pstk_r;
    dsp_nxt = dsp_r;
    hold_nxt = hold_r;
    from_int_nxt = from_int_r;
    ie_nxt = wr_ictl ? reg_wdata[0] : ie_r;
    dout_nxt = dout_r;
    done_nxt = 1'b0;
    pcld_nxt = 1'b0;
    flld_nxt = 1'b0;
    pc_nxt = pc_r;
    cy_nxt = cy_r;
    zf_nxt = zf_r;
    ram_we = 1'b0;
    ram_wa = pstk_r;
    ram_wd = save_hi;
    case (st_r)
      CSRU_ST_IDLE: begin
        if (accept) begin
          case (cmd)
            CSRU_CMD_INT_ACK, CSRU_CMD_CALL: begin
              if (cmd == CSRU_CMD_INT_ACK) begin
                ie_nxt = 1'b0;
              end
              ram_we = 1'b1;
              hold_nxt = pc_in[7:0];
              pstk_nxt = pstk_inc;
              st_nxt = CSRU_ST_SAVE2;
            end
            CSRU_CMD_INT_RETURN, CSRU_CMD_SUB_RETURN: begin
              pstk_nxt = pstk_dec;
              hold_nxt = ram_rd;
              from_int_nxt = (cmd == CSRU_CMD_INT_RETURN);
              st_nxt = CSRU_ST_REST2;
            end
            CSRU_CMD_PUSH: begin
              dsp_nxt = dsp_dec;
              ram_we = 1'b1;
              ram_wa = dsp_dec;
              ram_wd = accumulator;
              done_nxt = 1'b1;
            end
            CSRU_CMD_POP: begin
              dout_nxt = ram_rd;
              dsp_nxt = dsp_inc;
              done_nxt = 1'b1;
            end
            CSRU_CMD_LOAD_PSTK: begin
              pstk_nxt = accumulator;
              done_nxt = 1'b1;
            end
            CSRU_CMD_SWAP_DSP: begin
              dsp_nxt = accumulator;
              dout_nxt = dsp_r;
              done_nxt = 1'b1;
            end
            CSRU_CMD_RD: begin
              dout_nxt = (mode == CSRU_MODE_IMM) ? operand : ram_rd;
              done_nxt = 1'b1;
            end
            CSRU_CMD_WR: begin
              // Immediate has no location, so nothing is stored
              ram_we = (mode != CSRU_MODE_IMM);
              ram_wa = opnd_addr;
              ram_wd = accumulator;
              done_nxt = 1'b1;
            end
            CSRU_CMD_EI: begin
              ie_nxt = 1'b1;
              done_nxt = 1'b1;
            end
            CSRU_CMD_DI: begin
              ie_nxt = 1'b0;
              done_nxt = 1'b1;
            end
            default: begin
              done_nxt = 1'b1;
            end
          endcase
        end
      end
      CSRU_ST_SAVE2: begin
        ram_we = 1'b1;
        ram_wd = hold_r;
        pstk_nxt = pstk_inc;
        done_nxt = 1'b1;
        st_nxt = CSRU_ST_IDLE;
      end
      CSRU_ST_REST2: begin
        pstk_nxt = pstk_dec;
        pc_nxt = {ram_rd[5:0], hold_r};
        pcld_nxt = 1'b1;
        if (from_int_r) begin
          cy_nxt = ram_rd[7];
          zf_nxt = ram_rd[6];
          flld_nxt = 1'b1;
          ie_nxt = 1'b1;
        end
        done_nxt = 1'b1;
        st_nxt = CSRU_ST_IDLE;
      end
      default: begin
        st_nxt = CSRU_ST_IDLE;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      st_r <= CSRU_ST_IDLE;
      pstk_r <= `CSRU_PTR_RST;
      dsp_r <= `CSRU_PTR_RST;
      ie_r <= 1'b0;
      from_int_r <= 1'b0;
      hold_r <= 8'h00;
      done_r <= 1'b0;
      pcld_r <= 1'b0;
      flld_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      pstk_r <= pstk_nxt;
      dsp_r <= dsp_nxt;
      ie_r <= ie_nxt;
      from_int_r <= from_int_nxt;
      hold_r <= hold_nxt;
      done_r <= done_nxt;
      pcld_r <= pcld_nxt;
      flld_r <= flld_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    // fetch from zero, no stack write
    if (sys_rst) begin
      pc_r <= `CSRU_PC_RST;
      cy_r <= 1'b0;
      zf_r <= 1'b0;
      dout_r <= 8'h00;
      boot_r <= 1'b1;
    end else begin
      pc_r <= pc_nxt;
      cy_r <= cy_nxt;
      zf_r <= zf_nxt;
      dout_r <= dout_nxt;
      boot_r <= boot_r && !run_ok;
    end
  end

  // Content is undefined after reset, as firmware expects
  always_ff @(posedge core_clk) begin
    if (ram_we) begin
      mem[ram_wa] <= ram_wd;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Status and control; cause bits clear by writing zero, watchdog bit also by power-on reset
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      stat_r <= `CSRU_STAT_POR_VAL;
    end else if (watchdog_reset_source) begin
      stat_r <= {2'b01, 1'b0, stat_r[`CSRU_STAT_POR_BIT], 4'h1};
    end else if (wr_stat) begin
      stat_r <= {reg_wdata[7],
                 reg_wdata[6] & stat_r[`CSRU_STAT_WDT_BIT],
                 reg_wdata[5],
                 reg_wdata[4] & stat_r[`CSRU_STAT_POR_BIT],
                 reg_wdata[3:0]};
    end
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      uadr_r <= `CSRU_USBADDR_RST;
    end else if (wr_uadr) begin
      uadr_r <= reg_wdata[6:0];
    end
  end

  // Pointer values deliberately have no read path
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      rdat_r <= 8'h00;
    end else begin
      rdat_r <= reg_rd ? rd_val : 8'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Outputs
  assign busy = !idle;
  assign done = done_r;
  assign data_out = dout_r;
  assign pc_load = pcld_r || (boot_r && run_ok);
  assign flags_load = flld_r;
  assign pc_out = pc_r;
  assign carry_out = cy_r;
  assign zero_out = zf_r;
  assign int_enable = ie_r;
  assign cpu_run = run_ok;
  assign usb_dev_addr = uadr_r;
  assign reg_rdata = rdat_r;

  ////////////////////////////////////////////////////////////////////
  // Checks
  property p_pstk_rst;
    @(posedge core_clk) sys_rst |=> pstk_r == 8'h00 && !ie_r;
  endproperty
  a_pstk_rst: assert property (p_pstk_rst)
    else $error("program stack pointer not cleared by reset");

  property p_dsp_rst;
    @(posedge core_clk) sys_rst |=> dsp_r == 8'h00 && uadr_r == 7'h00;
  endproperty
  a_dsp_rst: assert property (p_dsp_rst)
    else $error("reset left data pointer or USB address set");

  property p_save_two;
    @(posedge core_clk) disable iff (sys_rst)
      accept && (cmd == CSRU_CMD_CALL || cmd == CSRU_CMD_INT_ACK)
      |=> pstk_r == $past(pstk_r) + 8'h01
      ##1 pstk_r == $past(pstk_r, 2) + 8'h02 && done;
  endproperty
  a_save_two: assert property (p_save_two)
    else $error("save did not advance pointer by two");

  property p_ack_di;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_INT_ACK |=> !int_enable [*2];
  endproperty
  a_ack_di: assert property (p_ack_di)
    else $error("interrupts stayed enabled on acknowledge");

  property p_sub_return_two;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_SUB_RETURN
      |-> ##2 pstk_r == $past(pstk_r, 2) - 8'h02 && pc_load && !flags_load;
  endproperty
  a_sub_return_two: assert property (p_sub_return_two)
    else $error("return did not drop pointer by two");

  property p_int_return_ie;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_INT_RETURN
      |-> ##2 int_enable && flags_load && pc_load;
  endproperty
  a_int_return_ie: assert property (p_int_return_ie)
    else $error("interrupts not enabled with restored state");

  logic [7:0] ram_wa_q;
  property p_push;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_PUSH
      |-> ram_we && ram_wa == dsp_r - 8'h01 ##1 dsp_r == ram_wa_q;
  endproperty
  always_ff @(posedge core_clk) begin
    ram_wa_q <= ram_wa;
  end
  a_push: assert property (p_push)
    else $error("push did not pre-decrement");

  property p_pop;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_POP
      |=> dsp_r == $past(dsp_r) + 8'h01 && data_out == $past(ram_rd);
  endproperty
  a_pop: assert property (p_pop)
    else $error("pop did not read then increment");

  property p_idx;
    @(posedge core_clk) disable iff (sys_rst)
      accept && cmd == CSRU_CMD_RD && mode == CSRU_MODE_IDX
      |-> ram_ra == operand + index_register;
  endproperty
  a_idx: assert property (p_idx)
    else $error("indexed address is not constant plus index");

  property p_wdt_cause;
    @(posedge core_clk) rst_b && watchdog_reset_source
      |=> stat_r[`CSRU_STAT_WDT_BIT] && stat_r[`CSRU_STAT_RUN_BIT];
  endproperty
  a_wdt_cause: assert property (p_wdt_cause)
    else $error("watchdog cause bit not recorded");
endmodule

// *** dv/csru_seq_model.sv ***
// Purpose: Sequencer model that issues one command per bench request
// Assumes: Bench holds the command fields until done
// Notes: Slow mode waits three cycles before raising the request
`timescale 1ns/100ps

module csru_seq_model (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // Bench request
  input wire logic go,
  input wire logic slow,
  // Core handshake
  input wire logic busy,
  input wire logic cpu_run,
  output logic cmd_valid
);
  logic pend_r;
  logic [1:0] wait_r;

  ////////////////////////////////////////////////////////////////////////
  // Request only when the core can take it, so nothing is silently lost
  always_ff @(posedge core_clk) begin
    if (!rst_b) begin
      pend_r <= 1'b0;
      wait_r <= 2'h0;
      cmd_valid <= 1'b0;
    end else begin
      cmd_valid <= 1'b0;
      if (go) begin
        pend_r <= 1'b1;
        wait_r <= slow ? 2'h3 : 2'h0;
      end else if (pend_r && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end else if (pend_r && !busy && cpu_run && !cmd_valid) begin
        cmd_valid <= 1'b1;
        pend_r <= 1'b0;
      end
    end
  end
endmodule

// *** dv/csru_core_tb_top.sv ***
// Purpose: Self-checking bench for the stack, reset and address unit
// Assumes: One clock; commands go through the sequencer model
// Notes: Stack frames are read back with direct-mode reads
`timescale 1ns/100ps

module csru_core_tb_top;
  import csru_pkg::*;
  logic core_clk, rst_b, watchdog_reset_source, pll_lock, go, slow;
  logic cmd_valid, busy, done, pc_load, flags_load, carry_out, zero_out;
  logic carry_in, zero_in, int_enable, cpu_run, reg_wr, reg_rd, pl, fl, bz;
  csru_cmd_t cmd;
  csru_mode_t mode;
  logic [7:0] operand, index_register, accumulator, data_out;
  logic [7:0] reg_addr, reg_wdata, reg_rdata;
  logic [13:0] pc_in, pc_out;
  logic [6:0] usb_dev_addr;
  int n_mismatch = 0;
  int checks_done = 0;

  csru_core csru_core_inst (.core_clk(core_clk), .rst_b(rst_b),
    .watchdog_reset_source(watchdog_reset_source), .pll_lock(pll_lock),
    .cmd_valid(cmd_valid), .cmd(cmd), .mode(mode), .operand(operand),
    .index_register(index_register), .accumulator(accumulator),
    .pc_in(pc_in), .carry_in(carry_in), .zero_in(zero_in), .busy(busy),
    .done(done), .data_out(data_out), .pc_load(pc_load),
    .flags_load(flags_load), .pc_out(pc_out), .carry_out(carry_out),
    .zero_out(zero_out), .int_enable(int_enable), .cpu_run(cpu_run),
    .usb_dev_addr(usb_dev_addr), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  csru_seq_model csru_seq_model_inst (.core_clk(core_clk), .rst_b(rst_b),
    .go(go), .slow(slow), .busy(busy), .cpu_run(cpu_run),
    .cmd_valid(cmd_valid));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [15:0] seen,
                     input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("Mismatches %0d, checks %0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // Done pulse stands one cycle, so the strobes are captured right there
  task automatic do_cmd(input csru_cmd_t c, input csru_mode_t m,
                        input logic [7:0] k, input logic [7:0] a);
    int i;
    @(posedge core_clk);
    cmd <= c;
    mode <= m;
    operand <= k;
    accumulator <= a;
    go <= 1'b1;
    @(posedge core_clk);
    go <= 1'b0;
    bz = 1'b0;
    for (i = 0; i < 20; i++) begin
      @(posedge core_clk);
      #1;
      if (busy === 1'b1) bz = 1'b1;
      if (done === 1'b1) break;
    end
    chk("done", done, 1'b1);
    pl = pc_load;
    fl = flags_load;
  endtask

  task automatic op(input csru_cmd_t c, input logic [7:0] a);
    do_cmd(c, CSRU_MODE_IMM, 8'h00, a);
  endtask

  task automatic ram_is(input logic [7:0] k, input logic [7:0] e);
    do_cmd(CSRU_CMD_RD, CSRU_MODE_DIR, k, 8'h00);
    chk("ram", data_out, e);
  endtask

  task automatic set_pc(input logic [13:0] p, input logic c, input logic z);
    @(posedge core_clk);
    pc_in <= p;
    carry_in <= c;
    zero_in <= z;
  endtask

  task automatic reg_put(input logic [7:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_is(input logic [7:0] a, input logic [7:0] e);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk("reg", reg_rdata, e);
  endtask

  // Boot strobe stands only in the first running cycle
  task automatic wait_boot();
    int i;
    for (i = 0; i < 30; i++) begin
      #1;
      if (cpu_run === 1'b1) break;
      @(posedge core_clk);
    end
    chk("run", cpu_run, 1'b1);
    chk("boot", pc_load, 1'b1);
    chk("boot_pc", pc_out, 14'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    wait_boot();
    reg_is(8'h00, 8'h11);
    reg_is(8'h01, 8'h00);
    reg_is(8'h02, 8'h00);
    reg_is(8'h07, 8'h00);
  endtask

  // Core must hold still while the PLL is out of lock
  task automatic t_pll();
    @(posedge core_clk);
    pll_lock <= 1'b0;
    @(posedge core_clk);
    #1;
    chk("run", cpu_run, 1'b0);
    @(posedge core_clk);
    pll_lock <= 1'b1;
    #1;
    chk("run", cpu_run, 1'b1);
  endtask

  task automatic t_int();
    op(CSRU_CMD_EI, 8'h00);
    chk("ie", int_enable, 1'b1);
    set_pc(14'h1234, 1'b0, 1'b1);
    op(CSRU_CMD_INT_ACK, 8'h00);
    chk("ie", int_enable, 1'b0);
    ram_is(8'h00, 8'h52);
    ram_is(8'h01, 8'h34);
    op(CSRU_CMD_INT_RETURN, 8'h00);
    chk("pc", pc_out, 14'h1234);
    chk("flags_load", fl, 1'b1);
    chk("flags", {carry_out, zero_out}, 2'b01);
    chk("ie", int_enable, 1'b1);
  endtask

  task automatic t_call_ret();
    set_pc(14'h2abc, 1'b1, 1'b0);
    op(CSRU_CMD_CALL, 8'h00);
    chk("busy", bz, 1'b1);
    ram_is(8'h00, 8'haa);
    ram_is(8'h01, 8'hbc);
    op(CSRU_CMD_SUB_RETURN, 8'h00);
    chk("busy", bz, 1'b1);
    chk("pc", pc_out, 14'h2abc);
    chk("pc_load", pl, 1'b1);
    chk("flags_load", fl, 1'b0);
    chk("flags", {carry_out, zero_out}, 2'b01);
  endtask

  // Frame straddles the top of RAM, so both wraps are exercised
  task automatic t_pstk_wrap();
    op(CSRU_CMD_LOAD_PSTK, 8'hff);
    set_pc(14'h0155, 1'b0, 1'b0);
    op(CSRU_CMD_CALL, 8'h00);
    ram_is(8'hff, 8'h01);
    ram_is(8'h00, 8'h55);
    op(CSRU_CMD_SUB_RETURN, 8'h00);
    chk("pc", pc_out, 14'h0155);
  endtask

  task automatic t_dsp();
    op(CSRU_CMD_PUSH, 8'h3c);
    chk("busy", bz, 1'b0);
    ram_is(8'hff, 8'h3c);
    op(CSRU_CMD_POP, 8'h00);
    chk("pop", data_out, 8'h3c);
    op(CSRU_CMD_SWAP_DSP, 8'h20);
    chk("swap", data_out, 8'h00);
    op(CSRU_CMD_PUSH, 8'h5a);
    ram_is(8'h1f, 8'h5a);
    op(CSRU_CMD_SWAP_DSP, 8'h00);
    chk("swap", data_out, 8'h1f);
  endtask

  task automatic t_modes();
    @(posedge core_clk);
    slow <= 1'b1;
    index_register <= 8'h03;
    do_cmd(CSRU_CMD_RD, CSRU_MODE_IMM, 8'hd8, 8'h00);
    chk("imm", data_out, 8'hd8);
    do_cmd(CSRU_CMD_WR, CSRU_MODE_DIR, 8'h10, 8'h77);
    ram_is(8'h10, 8'h77);
    do_cmd(CSRU_CMD_RD, CSRU_MODE_IDX, 8'h0d, 8'h00);
    chk("idx", data_out, 8'h77);
    do_cmd(CSRU_CMD_WR, CSRU_MODE_IMM, 8'h10, 8'h11);
    ram_is(8'h10, 8'h77);
    @(posedge core_clk);
    slow <= 1'b0;
  endtask

  task automatic t_wdt();
    reg_put(8'h01, 8'h2a);
    reg_is(8'h01, 8'h2a);
    chk("usb", usb_dev_addr, 7'h2a);
    reg_put(8'h00, 8'h01);
    reg_is(8'h00, 8'h01);
    op(CSRU_CMD_DI, 8'h00);
    chk("ie", int_enable, 1'b0);
    reg_put(8'h02, 8'h01);
    reg_is(8'h02, 8'h01);
    op(CSRU_CMD_LOAD_PSTK, 8'h40);
    @(posedge core_clk);
    watchdog_reset_source <= 1'b1;
    @(posedge core_clk);
    watchdog_reset_source <= 1'b0;
    wait_boot();
    reg_is(8'h00, 8'h41);
    reg_is(8'h01, 8'h00);
    chk("usb", usb_dev_addr, 7'h00);
    chk("ie", int_enable, 1'b0);
    set_pc(14'h0001, 1'b0, 1'b0);
    op(CSRU_CMD_CALL, 8'h00);
    ram_is(8'h00, 8'h00);
    ram_is(8'h01, 8'h01);
  endtask

  ////////////////////////////////////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    watchdog_reset_source = 1'b0;
    pll_lock = 1'b1;
    go = 1'b0;
    slow = 1'b0;
    cmd = CSRU_CMD_NONE;
    mode = CSRU_MODE_IMM;
    operand = 8'h00;
    index_register = 8'h00;
    accumulator = 8'h00;
    pc_in = 14'h0000;
    carry_in = 1'b0;
    zero_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    repeat (20) @(posedge core_clk);
    rst_b <= 1'b1;
    t_reset();
    t_pll();
    t_int();
    t_call_ret();
    t_pstk_wrap();
    t_dsp();
    t_modes();
    t_wdt();
    results();
  end

  // Whole run needs a few hundred cycles; this is far beyond that
  initial begin
    #300000;
    n_mismatch++;
    results();
  end
endmodule
